// file: core/bitop_regs.svh
`ifndef BITOP_REGS_SVH
`define BITOP_REGS_SVH
// Instruction word layout
`define BITOP_IW_W 14
`define BITOP_FA_W 7
`define BITOP_DATA_W 8
`define BITOP_BITSEL_LSB 7
`define BITOP_BITSEL_MSB 9
`define BITOP_FA_MSB 6
`define BITOP_FA_LSB 0
`define BITOP_DEST_BIT 7
`define BITOP_GRP_MSB 13
`define BITOP_GRP_LSB 12
`define BITOP_SUB_MSB 11
`define BITOP_SUB_LSB 10
`define BITOP_OP6_MSB 13
`define BITOP_OP6_LSB 8
// Opcode fields
`define BITOP_GRP_BIT 2'h1
`define BITOP_SUB_BCLR 2'h0
`define BITOP_SUB_BSET 2'h1
`define BITOP_SUB_BTSC 2'h2
`define BITOP_OP6_COMPLEMENT_REGISTER_OP 6'h09
`define BITOP_IW_CLEAR_ACCUMULATOR_OP 14'h0103
// Values
`define BITOP_ZERO8 8'h00
`define BITOP_ONE8 8'h01
`define BITOP_ZERO7 7'h00
`endif

// file: core/bitop_pkg.sv
package bitop_pkg;
    typedef struct packed {
        logic       we;
        logic [6:0] addr;
        logic [7:0] data;
    } bitop_fwr_t;
    typedef struct packed {
        logic       we;
        logic [7:0] data;
    } bitop_acc_t;
    typedef enum logic [1:0] {
        BITOP_RUN  = 2'h1,
        BITOP_FLSH = 2'h2
    } bitop_state_t;
endpackage

// file: core/bitop_mask.sv
`timescale 1ns/1ps
`include "bitop_regs.svh"
module bitop_mask (
    input wire logic [2:0] sel_i,
    output logic [7:0] mask_o
);
    // One-hot bit mask from the position select
    assign mask_o = `BITOP_ONE8 << sel_i;
endmodule // bitop_mask

// file: core/bitop_core.sv
`timescale 1ns/1ps
`include "bitop_regs.svh"
// Function
// - Bit clear zeroes one bit, flags kept
// - Bit set raises one bit, flags kept
// - Bit test skips next when bit zero
// - Taken skip flushes the next offered word, held until one comes
// - Clear accumulator loads zero, sets zero flag
// - Complement register to accumulator or register
module bitop_core (
    input wire logic REF_CLK_I,
    input wire logic RST_B_I,
    input wire logic IW_VALID_I,
    input wire logic [13:0] IW_I,
    input wire logic [7:0] FRD_DATA_I,
    output logic [6:0] FRD_ADDR_O,
    output bitop_pkg::bitop_fwr_t FWR_O,
    output bitop_pkg::bitop_acc_t ACC_O,
    output logic Z_WE_O,
    output logic Z_O,
    output logic FLUSH_O,
    output logic BUSY_O
);
    // ***************************************************
    // Instruction fields
    // ***************************************************
    wire logic [1:0] iw_grp = IW_I[`BITOP_GRP_MSB:`BITOP_GRP_LSB];
    wire logic [1:0] iw_sub = IW_I[`BITOP_SUB_MSB:`BITOP_SUB_LSB];
    wire logic [5:0] iw_op6 = IW_I[`BITOP_OP6_MSB:`BITOP_OP6_LSB];
    wire logic [6:0] iw_faddr = IW_I[`BITOP_FA_MSB:`BITOP_FA_LSB];
    wire logic [2:0] bit_sel = IW_I[`BITOP_BITSEL_MSB:`BITOP_BITSEL_LSB];
    wire logic dest_reg = IW_I[`BITOP_DEST_BIT];

    // Operand register is read in the cycle the word is offered
    assign FRD_ADDR_O = iw_faddr;

    // ***************************************************
    // Decode
    // ***************************************************
    // True for a bit-oriented word of the wanted subcode
    function automatic logic is_bit_sub(
        input logic [1:0] grp,
        input logic [1:0] sub,
        input logic [1:0] want
    );
        is_bit_sub = (grp == `BITOP_GRP_BIT) && (sub == want);
    endfunction

    // Passes the value when its select is set, zero otherwise
    function automatic logic [7:0] gate8(
        input logic sel,
        input logic [7:0] val
    );
        gate8 = sel ? val : `BITOP_ZERO8;
    endfunction

    bitop_pkg::bitop_state_t state_q;
    bitop_pkg::bitop_state_t state_d;

    // Words offered while a skip is pending never execute
    wire logic run_st = (state_q == bitop_pkg::BITOP_RUN);
    wire logic exec = IW_VALID_I && run_st;

    wire logic dec_clr = is_bit_sub(iw_grp, iw_sub, `BITOP_SUB_BCLR);
    wire logic dec_set = is_bit_sub(iw_grp, iw_sub, `BITOP_SUB_BSET);
    wire logic dec_tst = is_bit_sub(iw_grp, iw_sub, `BITOP_SUB_BTSC);
    wire logic dec_cacc = (IW_I == `BITOP_IW_CLEAR_ACCUMULATOR_OP);
    wire logic dec_comp = (iw_op6 == `BITOP_OP6_COMPLEMENT_REGISTER_OP);

    // ***************************************************
    // Operation select
    // ***************************************************
    wire logic op_clr = exec && dec_clr;
    wire logic op_set = exec && dec_set;
    wire logic op_tst = exec && dec_tst;
    wire logic op_cacc = exec && dec_cacc;
    wire logic op_comp = exec && dec_comp;
    wire logic op_rmw = op_clr || op_set;
    wire logic comp_to_reg = op_comp && dest_reg;
    wire logic comp_to_acc = op_comp && !dest_reg;

    // ***************************************************
    // Bit mask
    // ***************************************************
    wire logic [7:0] mask;

    bitop_mask u_mask (
        .sel_i(bit_sel),
        .mask_o(mask)
    );

    // ***************************************************
    // Per-bit datapath
    // ***************************************************
    wire logic [7:0] clr_val;
    wire logic [7:0] set_val;
    wire logic [7:0] comp_val;
    wire logic [7:0] tst_hit;

    genvar gi;
    generate
        for (gi = 0; gi < `BITOP_DATA_W; gi = gi + 1) begin : g_bit
            // For clear and set only the masked position changes; complement inverts every bit
            assign clr_val[gi] = FRD_DATA_I[gi] & ~mask[gi];
            assign set_val[gi] = FRD_DATA_I[gi] | mask[gi];
            assign comp_val[gi] = ~FRD_DATA_I[gi];
            assign tst_hit[gi] = FRD_DATA_I[gi] & mask[gi];
        end
    endgenerate

    wire logic bit_zero = (tst_hit == `BITOP_ZERO8);
    wire logic skip = op_tst && bit_zero;
    wire logic comp_zero = (comp_val == `BITOP_ZERO8);

    // ***************************************************
    // Register-file result
    // ***************************************************
    wire logic fwr_we_d = op_rmw || comp_to_reg;
    wire logic [7:0] fwr_data_d = gate8(op_clr, clr_val)
        | gate8(op_set, set_val)
        | gate8(op_comp, comp_val);
    bitop_pkg::bitop_fwr_t fwr_d;
    assign fwr_d = '{we: fwr_we_d, addr: iw_faddr, data: fwr_data_d};

    // ***************************************************
    // Accumulator result
    // ***************************************************
    // Clear loads zero, so only the complement needs a data path
    wire logic acc_we_d = op_cacc || comp_to_acc;
    wire logic [7:0] acc_data_d = gate8(op_comp, comp_val);
    bitop_pkg::bitop_acc_t acc_d;
    assign acc_d = '{we: acc_we_d, data: acc_data_d};

    // ***************************************************
    // Flag result
    // ***************************************************
    // Bit ops and the bit test never raise the flag write
    wire logic z_we_d = op_cacc || op_comp;
    wire logic z_d = op_cacc || (op_comp && comp_zero);

    // ***************************************************
    // Skip sequencer
    // ***************************************************
    // A taken test waits for the next offered word and drops it
    always_comb begin
        case (state_q)
            bitop_pkg::BITOP_RUN: begin
                state_d = skip ? bitop_pkg::BITOP_FLSH : bitop_pkg::BITOP_RUN;
            end
            bitop_pkg::BITOP_FLSH: begin
                state_d = IW_VALID_I ? bitop_pkg::BITOP_RUN : bitop_pkg::BITOP_FLSH;
            end
            default: begin
                state_d = bitop_pkg::BITOP_RUN;
            end
        endcase
    end

    // ***************************************************
    // Registers
    // ***************************************************
    // Idle values loaded by reset
    localparam bitop_pkg::bitop_fwr_t fwr_idle =
        '{we: 1'h0, addr: `BITOP_ZERO7, data: `BITOP_ZERO8};
    localparam bitop_pkg::bitop_acc_t acc_idle = '{we: 1'h0, data: `BITOP_ZERO8};

    bitop_pkg::bitop_fwr_t fwr_q;
    bitop_pkg::bitop_acc_t acc_q;
    logic z_we_q;
    logic z_q;

    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_q <= bitop_pkg::BITOP_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            fwr_q <= fwr_idle;
        end else begin
            fwr_q <= fwr_d;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            acc_q <= acc_idle;
        end else begin
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            z_we_q <= 1'h0;
        end else begin
            z_we_q <= z_we_d;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            z_q <= 1'h0;
        end else begin
            z_q <= z_d;
        end
    end

    // ***************************************************
    // Outputs
    // ***************************************************
    assign FWR_O = fwr_q;
    assign ACC_O = acc_q;
    assign Z_WE_O = z_we_q;
    assign Z_O = z_q;
    // Fetched word is discarded as a no-operation while flushing
    assign FLUSH_O = (state_q == bitop_pkg::BITOP_FLSH);
    assign BUSY_O = FLUSH_O;
endmodule // bitop_core

// file: bench/bitop_core_chk.sv
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module bitop_core_chk (
    input wire logic REF_CLK_I,
    input wire logic RST_B_I,
    input wire logic IW_VALID_I,
    input wire logic [13:0] IW_I,
    input wire logic [7:0] FRD_DATA_I,
    input wire logic [6:0] FRD_ADDR_O,
    input wire bitop_pkg::bitop_fwr_t FWR_O,
    input wire bitop_pkg::bitop_acc_t ACC_O,
    input wire logic Z_WE_O,
    input wire logic Z_O,
    input wire logic FLUSH_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_B_I);
    wire take = IW_VALID_I && !FLUSH_O;
    a_clear_one_bit: assert property (take && IW_I[13:10] == 4'h4 |=> FWR_O.we && !Z_WE_O
        && FWR_O.data == ($past(FRD_DATA_I) & ~(8'h01 << $past(IW_I[9:7]))))
        else $error("bit clear result wrong");
    a_set_one_bit: assert property (take && IW_I[13:10] == 4'h5 |=> FWR_O.we && !Z_WE_O
        && FWR_O.data == ($past(FRD_DATA_I) | (8'h01 << $past(IW_I[9:7]))))
        else $error("bit set result wrong");
    a_skip_on_clear: assert property (take && IW_I[13:10] == 4'h6
        |=> FLUSH_O == !$past(FRD_DATA_I[IW_I[9:7]]) && !Z_WE_O && !FWR_O.we)
        else $error("bit test skip wrong");
    a_flush_drops_word: assert property (FLUSH_O && IW_VALID_I
        |=> !FWR_O.we && !ACC_O.we && !Z_WE_O && !FLUSH_O) else $error("skipped word ran");
    a_clear_acc_zero: assert property (take && IW_I == 14'h0103
        |=> ACC_O.we && ACC_O.data == 8'h00 && Z_WE_O && Z_O) else $error("clear acc wrong");
    a_complement_dest: assert property (take && IW_I[13:8] == 6'h09 |=> Z_WE_O
        && Z_O == ($past(FRD_DATA_I) == 8'hff) && ($past(IW_I[7]) ? FWR_O.we
        && FWR_O.data == ~$past(FRD_DATA_I) : ACC_O.we && ACC_O.data == ~$past(FRD_DATA_I)))
        else $error("complement wrong");
    a_rmw_same_reg: assert property (take && IW_I[13:11] == 3'h2
        |-> FRD_ADDR_O == IW_I[6:0] ##1 FWR_O.addr == $past(IW_I[6:0]))
        else $error("write address wrong");
endmodule // bitop_core_chk
bind bitop_core bitop_core_chk i_chk (.REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I),
    .IW_VALID_I(IW_VALID_I), .IW_I(IW_I), .FRD_DATA_I(FRD_DATA_I), .FRD_ADDR_O(FRD_ADDR_O),
    .FWR_O(FWR_O), .ACC_O(ACC_O), .Z_WE_O(Z_WE_O), .Z_O(Z_O), .FLUSH_O(FLUSH_O));

// file: bench/bit_op_instruction_decode_test.sv
`timescale 1ns/1ps
module bit_op_instruction_decode_test;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic vld = 1'h0;
    logic [13:0] iw = 14'h0000;
    logic [7:0] frd = 8'h00;
    logic [6:0] fa;
    bitop_pkg::bitop_fwr_t fwr;
    bitop_pkg::bitop_acc_t acc;
    logic zwe, z, fl, busy;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    bitop_core i_dut (.REF_CLK_I(clk), .RST_B_I(rst_b), .IW_VALID_I(vld), .IW_I(iw),
        .FRD_DATA_I(frd), .FRD_ADDR_O(fa), .FWR_O(fwr), .ACC_O(acc), .Z_WE_O(zwe),
        .Z_O(z), .FLUSH_O(fl), .BUSY_O(busy));
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task issue(input logic [13:0] w, input logic [7:0] d);
        @(posedge clk);
        iw <= w;
        frd <= d;
        vld <= 1'h1;
        @(posedge clk);
        vld <= 1'h0;
        #1;
    endtask
    task t_bits;
        for (int b = 0; b < 8; b++) begin
            issue({4'h4, b[2:0], 7'h05}, 8'hc7);
            chk("clr", {1'h1, 7'h05, 8'hc7 & ~(8'h01 << b)}, fwr);
            chk("clr_zwe", 16'h0000, {15'h0000, zwe});
            chk("faddr", 16'h0005, {9'h000, fa});
            issue({4'h5, b[2:0], 7'h7f}, 8'h0a);
            chk("set", {1'h1, 7'h7f, 8'h0a | (8'h01 << b)}, fwr);
        end
    endtask
    task t_skip;
        issue({4'h6, 3'h1, 7'h10}, 8'hfd);
        chk("flush", 16'h0001, {15'h0000, fl});
        chk("busy", 16'h0001, {15'h0000, busy});
        issue({4'h5, 3'h0, 7'h10}, 8'h00);
        chk("drop", 16'h0000, {fwr.we, acc.we, zwe, fl, 12'h000});
        issue({4'h6, 3'h1, 7'h10}, 8'h02);
        chk("noskip", 16'h0000, {15'h0000, fl});
    endtask
    task t_acc;
        issue(14'h0103, 8'h5a);
        chk("clracc", 16'h0100, {7'h00, acc});
        chk("clracc_z", 16'h0003, {14'h0000, zwe, z});
        issue({6'h09, 1'h0, 7'h22}, 8'hff);
        chk("com_acc", 16'h0100, {7'h00, acc});
        chk("com_z", 16'h0003, {14'h0000, zwe, z});
        issue({6'h09, 1'h1, 7'h22}, 8'h5a);
        chk("com_reg", {1'h1, 7'h22, 8'ha5}, fwr);
        chk("com_z1", 16'h0002, {14'h0000, zwe, z});
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        t_bits();
        t_skip();
        t_acc();
        summarize();
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 500) begin
            bad_count++;
            summarize();
        end
    end
endmodule // bit_op_instruction_decode_test
